// ==== uiem_pkg.sv ====
/*
 * uiem_pkg: constants shared by the usb interrupt enable mask block.
 * assumes a 32-bit avalon-mm register bus with word addressing in bytes.
 */
package uiem_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned ADDR_W           = 4;
  localparam logic [3:0]  OFS_ENABLE_MASK  = 4'h0;
  localparam logic [3:0]  OFS_EVENT_STATUS = 4'h4;
  localparam logic [3:0]  OFS_MODE         = 4'h8;
  localparam logic [3:0]  OFS_EVENT_RAW    = 4'hC;

  // ****************************************************************
  // field positions in enable, status, raw event and mode words
  // ****************************************************************
  localparam int unsigned BIT_RESET_DETACH = 0;
  localparam int unsigned BIT_FAULT        = 1;
  localparam int unsigned BIT_FRAME_START  = 2;
  localparam int unsigned BIT_TOKEN_DONE   = 3;
  localparam int unsigned BIT_IDLE         = 4;
  localparam int unsigned BIT_RESUME       = 5;
  localparam int unsigned BIT_ATTACH       = 6;
  localparam int unsigned BIT_STALL        = 7;
  localparam int unsigned EVENT_W          = 8;
  localparam int unsigned BIT_HOST_MODE    = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  RST_ENABLE_MASK  = 8'h00;
  localparam logic [7:0]  RST_STATUS       = 8'h00;
  localparam logic        RST_HOST_MODE    = 1'h0;

  typedef logic [7:0] uiem_evt_t;

endpackage : uiem_pkg

// ==== uiem_sticky.sv ====
/*
 * uiem_sticky: sticky event flags, set by event pulses, cleared on read.
 * assumes events are synchronous to CLK.
 */
`timescale 1ns/1ps
module uiem_sticky #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic             clear_all,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags_reg;
  } uiem_sticky_state_t;

  uiem_sticky_state_t st_reg;
  uiem_sticky_state_t st_next;

  // set wins over a clear in the same cycle
  always_comb begin
    st_next = st_reg;
    if (clear_all) begin
      st_next.flags_reg = '0;
    end
    st_next.flags_reg = st_next.flags_reg | set_in;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags_reg;

endmodule : uiem_sticky

// ==== uiem_gate.sv ====
/*
 * uiem_gate: and-or reduction of flags against enables to one request.
 * assumes both vectors share one bit layout.
 */
`timescale 1ns/1ps
module uiem_gate #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] flags,
  input  wire logic [WIDTH-1:0] enables,
  output logic                  request
);

  assign request = |(flags & enables);

endmodule : uiem_gate

// ==== uiem_top.sv ====
/*
 * uiem_top: usb interrupt enable mask with avalon-mm slave access.
 * assumes usb engine event pulses are synchronous to CLK.
 */
// How it works
// - stall event reaches usb request only while enable bit 7 is one.
// - attach event passes only while enable bit 6 is one.
// - resume event passes only while enable bit 5 is one.
// - idle event passes only while enable bit 4 is one.
// - token done flag passes only while enable bit 3 is one.
// - frame start flag passes only while enable bit 2 is one.
// - usb fault event passes only while enable bit 1 is one.
// - bit 0 enables bus reset in device mode, detach in host mode.
// - error class events reach the combined request only with bit 1 set.
// - mask bits 31 to 8 read zero and ignore writes.
`timescale 1ns/1ps
module uiem_top
  import uiem_pkg::*;
#(
  parameter int unsigned EVT_W = uiem_pkg::EVENT_W
) (
  input  wire logic                        CLK,
  input  wire logic                        RST,
  input  wire logic [uiem_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [31:0]                 AVS_WRITEDATA,
  input  wire logic [3:0]                  AVS_BYTEENABLE,
  output logic      [31:0]                 AVS_READDATA,
  output logic                             AVS_WAITREQUEST,
  input  wire logic                        EVT_STALL,
  input  wire logic                        EVT_ATTACH,
  input  wire logic                        EVT_RESUME,
  input  wire logic                        EVT_IDLE,
  input  wire logic                        EVT_TOKEN_DONE,
  input  wire logic                        EVT_FRAME_START,
  input  wire logic                        EVT_FAULT,
  input  wire logic                        EVT_BUS_RESET,
  input  wire logic                        EVT_DETACH,
  output logic                             USB_COMBINED_IRQ,
  output logic                             HOST_MODE
);
  import uiem_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } uiem_bus_t;

  typedef struct packed {
    uiem_bus_t   bus_reg;
    logic [7:0]  enable_mask_reg;
    logic        host_mode_reg;
    logic [31:0] rdata_reg;
  } uiem_state_t;

  uiem_state_t st_reg;
  uiem_state_t st_next;

  uiem_evt_t   events;
  uiem_evt_t   flags;
  logic        status_rd;
  logic        req;
  logic        access;

  // ****************************************************************
  // event vector
  // ****************************************************************
  always_comb begin
    events                   = '0;
    events[BIT_STALL]        = EVT_STALL;
    events[BIT_ATTACH]       = EVT_ATTACH;
    events[BIT_RESUME]       = EVT_RESUME;
    events[BIT_IDLE]         = EVT_IDLE;
    events[BIT_TOKEN_DONE]   = EVT_TOKEN_DONE;
    events[BIT_FRAME_START]  = EVT_FRAME_START;
    events[BIT_FAULT]        = EVT_FAULT;
    // shared bit follows the operating role
    events[BIT_RESET_DETACH] = st_reg.host_mode_reg ? EVT_DETACH
                                                    : EVT_BUS_RESET;
  end

  // ****************************************************************
  // sticky status and gating
  // ****************************************************************
  assign access    = (st_reg.bus_reg == BUS_IDLE) && (AVS_READ || AVS_WRITE);
  assign status_rd = access && AVS_READ && (AVS_ADDRESS == OFS_EVENT_STATUS);

  uiem_sticky #(
    .WIDTH (EVT_W)
  ) u_sticky (
    .clk       (CLK),
    .rst       (RST),
    .set_in    (events),
    .clear_all (status_rd),
    .flags     (flags)
  );

  // each flag is and-ed with its enable bit before the or
  uiem_gate #(
    .WIDTH (EVT_W)
  ) u_gate (
    .flags   (flags),
    .enables (st_reg.enable_mask_reg),
    .request (req)
  );

  // ****************************************************************
  // avalon-mm slave: one wait cycle, answer on the second edge
  // ****************************************************************
  function automatic logic [7:0] merge_byte0(input logic [7:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    merge_byte0 = be[0] ? wd[7:0] : old_v;
  endfunction : merge_byte0

  always_comb begin
    st_next = st_reg;
    unique case (st_reg.bus_reg)
      BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          st_next.bus_reg   = BUS_ACK;
          st_next.rdata_reg = 32'h0000_0000;
          if (AVS_READ) begin
            unique case (AVS_ADDRESS)
              OFS_ENABLE_MASK:
                st_next.rdata_reg = {24'h00_0000,
                                     st_reg.enable_mask_reg};
              OFS_EVENT_STATUS:
                st_next.rdata_reg = {24'h00_0000, flags};
              OFS_MODE:
                st_next.rdata_reg = {31'h0000_0000,
                                     st_reg.host_mode_reg};
              OFS_EVENT_RAW:
                st_next.rdata_reg = {24'h00_0000, events};
              default:
                st_next.rdata_reg = 32'h0000_0000;
            endcase
          end else begin
            unique case (AVS_ADDRESS)
              OFS_ENABLE_MASK:
                // upper lanes dropped, those bits do not exist
                st_next.enable_mask_reg =
                  merge_byte0(st_reg.enable_mask_reg, AVS_WRITEDATA,
                              AVS_BYTEENABLE);
              OFS_MODE:
                if (AVS_BYTEENABLE[0]) begin
                  st_next.host_mode_reg = AVS_WRITEDATA[BIT_HOST_MODE];
                end
              default: ;
            endcase
          end
        end
      end
      BUS_ACK: begin
        st_next.bus_reg = BUS_IDLE;
      end
      default: begin
        st_next.bus_reg = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg.bus_reg         <= BUS_IDLE;
      st_reg.enable_mask_reg <= RST_ENABLE_MASK;
      st_reg.host_mode_reg   <= RST_HOST_MODE;
      st_reg.rdata_reg       <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign AVS_WAITREQUEST  = (AVS_READ || AVS_WRITE) &&
                            (st_reg.bus_reg != BUS_ACK);
  assign AVS_READDATA     = st_reg.rdata_reg;
  assign USB_COMBINED_IRQ = req;
  assign HOST_MODE        = st_reg.host_mode_reg;

endmodule : uiem_top

// ==== uiem_monitor.sv ====
/* uiem_monitor: port assertions for the usb interrupt enable mask.
   assumes bind to uiem_top, one clock CLK, RST synchronous high. */
`timescale 1ns/1ps
module uiem_monitor (
  input wire logic        CLK, RST, AVS_READ, AVS_WRITE,
  input wire logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA, AVS_READDATA,
  input wire logic        AVS_WAITREQUEST, USB_COMBINED_IRQ, HOST_MODE,
  input wire logic        EVT_STALL, EVT_ATTACH, EVT_RESUME, EVT_IDLE,
  input wire logic        EVT_TOKEN_DONE, EVT_FRAME_START, EVT_FAULT,
  input wire logic        EVT_BUS_RESET, EVT_DETACH
);
  // ****************************************************************
  // shadow of mask and sticky status
  // ****************************************************************
  logic [7:0] msk_reg, st_reg;
  wire logic [7:0] ev = {EVT_STALL, EVT_ATTACH, EVT_RESUME, EVT_IDLE,
    EVT_TOKEN_DONE, EVT_FRAME_START, EVT_FAULT,
    HOST_MODE ? EVT_DETACH : EVT_BUS_RESET};
  always_ff @(posedge CLK) begin
    if (RST) begin
      msk_reg <= 8'h00;
      st_reg  <= 8'h00;
    end else begin
      if (AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == 4'h0
          && AVS_BYTEENABLE[0])
        msk_reg <= AVS_WRITEDATA[7:0];
      st_reg <= (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 4'h4)
                ? ev : (st_reg | ev);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_gate(int i);
    st_reg[i] && msk_reg[i] |-> USB_COMBINED_IRQ;
  endproperty
  a_stall_pass: assert property (p_gate(7))
    else $error("stall event not passed");
  a_attach_pass: assert property (p_gate(6))
    else $error("attach event not passed");
  a_resume_pass: assert property (p_gate(5))
    else $error("resume event not passed");
  a_idle_pass: assert property (p_gate(4))
    else $error("idle event not passed");
  a_token_pass: assert property (p_gate(3))
    else $error("token done not passed");
  a_frame_pass: assert property (p_gate(2))
    else $error("frame start not passed");
  a_fault_pass: assert property (p_gate(1))
    else $error("fault event not passed");
  a_bit0_pass: assert property (p_gate(0))
    else $error("bit 0 event not passed");
  a_irq_cause: assert property (USB_COMBINED_IRQ |->
    (st_reg & msk_reg) != 8'h00) else $error("request without cause");
  a_upper_zero: assert property (AVS_READ && !AVS_WAITREQUEST
    && AVS_ADDRESS == 4'h0 |-> AVS_READDATA == {24'h000000, msk_reg})
    else $error("mask read value wrong");
  a_reset_quiet: assert property (disable iff (1'b0) RST |=>
    !USB_COMBINED_IRQ && !HOST_MODE) else $error("reset not quiet");
  c_irq: cover property (USB_COMBINED_IRQ);
  c_host: cover property (HOST_MODE && EVT_DETACH);
  c_clear: cover property (USB_COMBINED_IRQ ##1 !USB_COMBINED_IRQ);
endmodule : uiem_monitor
bind uiem_top uiem_monitor uiem_monitor_inst (.*);

// ==== tb.sv ====
/* tb: self-checking bench for uiem_top with an integer reference model.
   assumes the monitor is bound to uiem_top. */
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // stimulus, model and checks
  // ****************************************************************
  logic        CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0;
  logic [3:0]  AVS_ADDRESS = 0, AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, q;
  logic        AVS_WAITREQUEST, USB_COMBINED_IRQ, HOST_MODE;
  logic [8:0]  ev = 9'h000;
  logic [15:0] lf = 16'h49E0;
  wire logic   EVT_STALL, EVT_ATTACH, EVT_RESUME, EVT_IDLE, EVT_TOKEN_DONE,
               EVT_FRAME_START, EVT_FAULT, EVT_BUS_RESET, EVT_DETACH;
  int          n_fail = 0, n_compared = 0, mk = 0, st = 0, md = 0;
  assign {EVT_DETACH, EVT_STALL, EVT_ATTACH, EVT_RESUME, EVT_IDLE,
          EVT_TOKEN_DONE, EVT_FRAME_START, EVT_FAULT, EVT_BUS_RESET} = ev;
  initial forever #50 CLK = ~CLK;
  uiem_top uiem_top_inst (.*);
  function logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  task end_sim;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input int exp);
    n_compared++;
    if (got !== exp[31:0]) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    k = 0;
    // waitrequest and read data are both taken at the same rising edge
    do begin
      @(posedge CLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
    if (AVS_WAITREQUEST !== 1'b0) begin
      n_fail++;
      $display("MISMATCH %0t bus wait timed out", $time);
      end_sim();
    end
    q = AVS_READDATA;
    AVS_WRITE <= 0;
    AVS_READ <= 0;
  endtask : bus
  task fire(input logic [8:0] e);
    @(posedge CLK);
    ev <= e;
    @(posedge CLK);
    ev <= 9'h000;
    st = st | {e[7:1], (md != 0) ? e[8] : e[0]};
    #1 chk(USB_COMBINED_IRQ, (st & mk) != 0);
  endtask : fire
  task take_status;
    bus(0, 4'h4, 0);
    chk(q, st);
    st = 0;
    chk(USB_COMBINED_IRQ, 0);
  endtask : take_status
  initial begin
    logic [8:0] x, y;
    repeat (2) @(posedge CLK);
    RST <= 0;
    bus(0, 4'h0, 0); chk(q, 0);
    take_status();
    for (int m = 0; m < 2; m++) begin
      bus(1, 4'h8, m); md = m; chk(HOST_MODE, m);
      bus(0, 4'h8, 0);
      chk(q, m);
      for (int i = 0; i < 8; i++) begin
        bus(1, 4'h0, 32'hFFFFFF00 | (32'h1 << i)); mk = 1 << i;
        bus(0, 4'h0, 0); chk(q, mk);
        x = (i == 0) ? 9'h101 : (9'h001 << i);
        y = (i == 0) ? ((m != 0) ? 9'h001 : 9'h100) : 9'h000;
        fire((9'h1FF & ~x) | y);
        take_status();
        fire(x);
        take_status();
      end
    end
    for (int r = 0; r < 24; r++) begin
      lf = nx(lf); bus(1, 4'h0, {16'h0000, lf}); mk = lf[7:0];
      lf = nx(lf); md = lf[9]; bus(1, 4'h8, {31'h0, lf[9]});
      fire(lf[8:0]);
      take_status();
    end
    AVS_BYTEENABLE <= 4'hE;
    bus(1, 4'h0, 32'h000000FF);
    AVS_BYTEENABLE <= 4'hF;
    bus(0, 4'h0, 0); chk(q, mk);
    bus(0, 4'h2, 0); chk(q, 0);
    @(posedge CLK) RST <= 1;
    @(posedge CLK) RST <= 0;
    mk = 0; st = 0; md = 0;
    bus(0, 4'h0, 0); chk(q, 0);
    chk(HOST_MODE, 0);
    // raw view: both bit 0 sources high, device role picks bus reset
    ev <= 9'h155;
    bus(0, 4'hC, 0);
    ev <= 9'h000;
    st = 8'h55;
    chk(q, 32'h55);
    take_status();
    end_sim();
  end
  initial begin
    #2000000 n_fail++;
    $display("MISMATCH %0t run timed out", $time);
    end_sim();
  end
endmodule : tb
